// [shared/cfgio_defs.svh]
`ifndef CFGIO_DEFS_SVH
`define CFGIO_DEFS_SVH
// Summary of operation
// - In I/O mode a pin drives when its direction flop is 1, else input.
// - An output pin drives the level held in its output data flop.
// - Host reads back direction and data flops, and separately the pin levels.
// - Each I/O, address or select output pin is individually CMOS or open-drain (bus modes are CMOS); open-drain needs a pull-up.
// - Port A bits may output address bits latched at the trailing edge of ALE.
// - With track select set in multiplexed mode, Port A is a bidirectional buffer for the low bus.
// - Track mode: address-out decode with ALE passes bus address out through Port A.
// - Track mode: active write decode drives low bus data out through Port A.
// - Track mode: read decode with read strobe drives Port A onto the low bus.
// - Track mode: Port A floats when no steering condition holds.
// - Non-multiplexed mode: Port A is the low data byte for reads and writes.
// - Port B bits may output active-low chip-selects, bit i carrying select i.
// - Selects 0-3 OR up to four product terms; selects 4-7 up to two.
// - 16-bit non-multiplexed mode: Port B is the high data byte.
// - 8-bit mode offsets from base: A pin 2, dir 4, data 6; B 3, 5, 7.
// - Pin-level registers answer reads only; writes to them change nothing.
// - 16-bit mode: Port B on the high byte, reached only with high byte enable low.
// - A blank configuration has every configuration bit at zero.

// ==========================================================
// Register offsets from the port base select
`define CFGIO_OFF_PIN_A 3'h2
`define CFGIO_OFF_PIN_B 3'h3
`define CFGIO_OFF_DIR_A 3'h4
`define CFGIO_OFF_DIR_B 3'h5
`define CFGIO_OFF_DAT_A 3'h6
`define CFGIO_OFF_DAT_B 3'h7

// ==========================================================
// Reset values
`define CFGIO_DIR_RST 8'h00
`define CFGIO_DAT_RST 8'h00
`define CFGIO_LATCH_RST 8'h00

// ==========================================================
// Chip-select product term counts
`define CFGIO_PT_WIDE 4
`define CFGIO_PT_NARROW 2
`define CFGIO_PT_TOTAL 24
`endif

// [shared/cfgio_pkg.sv]
package cfgio_pkg;
	// Static configuration; all-zero is the blank part.
	typedef struct packed {
		logic dataWide;
		logic muxMode;
		logic strobeStyleSelect;
		logic aleActiveLow;
		logic portATrackSelect;
		logic [7:0] addrOutSelect;
		logic [7:0] portAOutputDriveSelect;
		logic [7:0] portBIoSelect;
		logic [7:0] portBOutputDriveSelect;
	} cfgio_cfg_type;

	// Host-side signals, all asynchronous to clk.
	typedef struct packed {
		logic ale;
		logic rdE;
		logic wrRw;
		logic highByteEnableN;
		logic ioPortBaseSelect;
		logic memSelect;
		logic shareReadDecode;
		logic shareAddrOutDecode;
		logic shareWriteDecode;
		logic [7:0] lowAddrDataBus;
		logic [7:0] highAddrDataBus;
		logic [2:0] addr;
	} cfgio_bus_type;
endpackage

// [rtl/cfgio_cs_term.sv]
`timescale 1ns/100ps
module cfgio_cs_term #(
	parameter int TERMS = 4
) (
	input wire logic [TERMS-1:0] terms,
	output logic csN
);
	// ==========================================================
	// Sum of product terms, inverted to an active-low select.
	assign csN = ~|terms;
endmodule

// [rtl/cfgio_pin_cell.sv]
`timescale 1ns/100ps
module cfgio_pin_cell (
	input wire logic clk,
	input wire logic rst,
	input wire logic pinIn,
	input wire logic ioDrive,
	input wire logic ioVal,
	input wire logic altOn,
	input wire logic altDrive,
	input wire logic altVal,
	input wire logic openDrain,
	output logic pinOut,
	output logic pinOe,
	output logic pinLevel
);
	logic pinMeta;
	logic drive;
	logic value;
	logic next_pinOut;
	logic next_pinOe;

	// ==========================================================
	// An open-drain pin only ever pulls low, so a high value releases it.
	always_comb begin
		drive = altOn ? altDrive : ioDrive;
		value = altOn ? altVal : ioVal;
		next_pinOut = value & ~openDrain;
		next_pinOe = drive & (~openDrain | ~value);
	end

	// Output registers and the two-stage input synchroniser.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinOut <= 1'b0;
			pinOe <= 1'b0;
			pinMeta <= 1'b0;
			pinLevel <= 1'b0;
		end else begin
			pinOut <= next_pinOut;
			pinOe <= next_pinOe;
			pinMeta <= pinIn;
			pinLevel <= pinMeta;
		end
	end
endmodule

// [rtl/cfgio_ports.sv]
`timescale 1ns/100ps
`include "cfgio_defs.svh"
module cfgio_ports import cfgio_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire cfgio_cfg_type cfg,
	input wire cfgio_bus_type busIn,
	input wire logic [`CFGIO_PT_TOTAL-1:0] productTerms,
	input wire logic [15:0] memRdData,
	input wire logic [7:0] portAPinsIn,
	output logic [7:0] portAPinsOut,
	output logic [7:0] portAPinsOe,
	input wire logic [7:0] portBPinsIn,
	output logic [7:0] portBPinsOut,
	output logic [7:0] portBPinsOe,
	output logic [7:0] lowBusOut,
	output logic [7:0] lowBusOe,
	output logic [7:0] highBusOut,
	output logic [7:0] highBusOe,
	output logic [7:0] chipSelectOutputs,
	output logic [15:0] memWrData,
	output logic memWrLow,
	output logic memWrHigh
);
	// ==========================================================
	// Host synchronisers
	cfgio_bus_type busMeta;
	cfgio_bus_type bus;

	// Every host signal crosses two flops; only the second stage is read.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busMeta <= '0;
			bus <= '0;
		end else begin
			busMeta <= busIn;
			bus <= busMeta;
		end
	end

	// ==========================================================
	// Strobe and mode decode
	logic aleOn;
	logic rdOn;
	logic wrOn;
	logic nonMux;
	logic track;
	logic wideNonMux;
	logic [7:0] pinLevelA;
	logic [7:0] pinLevelB;
	logic [7:0] loLane;
	logic [7:0] hiLane;
	logic [2:0] regOff;
	logic [7:0] addrLatch;

	// The strobe style picks separate strobes or enable plus direction.
	always_comb begin
		aleOn = cfg.aleActiveLow ? ~bus.ale : bus.ale;
		rdOn = cfg.strobeStyleSelect ? (bus.rdE & bus.wrRw) : ~bus.rdE;
		wrOn = cfg.strobeStyleSelect ? (bus.rdE & ~bus.wrRw) : ~bus.wrRw;
		nonMux = ~cfg.muxMode;
		track = cfg.muxMode & cfg.portATrackSelect;
		wideNonMux = cfg.dataWide & nonMux;
		loLane = nonMux ? pinLevelA : bus.lowAddrDataBus;
		hiLane = nonMux ? pinLevelB : bus.highAddrDataBus;
		regOff = cfg.muxMode ? addrLatch[2:0] : bus.addr;
	end

	// ==========================================================
	// Port registers and write path
	logic [7:0] portADirection;
	logic [7:0] portBDirection;
	logic [7:0] portAOutputData;
	logic [7:0] portBOutputData;
	logic wrQ;
	logic [7:0] wrLo;
	logic [7:0] wrHi;
	logic [2:0] wrOff;
	logic wrHit;
	logic wrMem;
	logic wrBheN;
	logic [7:0] next_addrLatch;
	logic [7:0] next_portADirection;
	logic [7:0] next_portBDirection;
	logic [7:0] next_portAOutputData;
	logic [7:0] next_portBOutputData;
	logic [15:0] next_memWrData;
	logic next_memWrLow;
	logic next_memWrHigh;
	logic wrCommit;
	logic wrATgt;
	logic wrBTgt;
	logic [2:0] wrBase;
	logic [7:0] wrBLane;

	// Data and address are resampled every cycle the strobe is active and committed
	// at its trailing edge, so bus settling inside the pulse does no harm.
	always_comb begin
		next_addrLatch = (cfg.muxMode & aleOn) ? bus.lowAddrDataBus : addrLatch;
		wrCommit = wrQ & ~wrOn;
		wrBase = {wrOff[2:1], 1'b0};
		wrATgt = ~wrOff[0];
		wrBTgt = cfg.dataWide ? ~wrBheN : wrOff[0];
		wrBLane = cfg.dataWide ? wrHi : wrLo;
		next_portADirection = portADirection;
		next_portBDirection = portBDirection;
		next_portAOutputData = portAOutputData;
		next_portBOutputData = portBOutputData;
		// Pin-level offsets fall through untouched.
		if (wrCommit & wrHit) begin
			if (wrBase == `CFGIO_OFF_DIR_A) begin
				next_portADirection = wrATgt ? wrLo : portADirection;
				next_portBDirection = wrBTgt ? wrBLane : portBDirection;
			end
			if (wrBase == `CFGIO_OFF_DAT_A) begin
				next_portAOutputData = wrATgt ? wrLo : portAOutputData;
				next_portBOutputData = wrBTgt ? wrBLane : portBOutputData;
			end
		end
		next_memWrData = {wrHi, wrLo};
		next_memWrLow = wrCommit & wrMem & ~wrHit & (~cfg.dataWide | wrATgt);
		next_memWrHigh = wrCommit & wrMem & ~wrHit & cfg.dataWide & ~wrBheN;
	end

	// Registers only; reset leaves every I/O pin an input.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addrLatch <= `CFGIO_LATCH_RST;
			portADirection <= `CFGIO_DIR_RST;
			portBDirection <= `CFGIO_DIR_RST;
			portAOutputData <= `CFGIO_DAT_RST;
			portBOutputData <= `CFGIO_DAT_RST;
			wrQ <= 1'b0;
			wrLo <= 8'h00;
			wrHi <= 8'h00;
			wrOff <= 3'h0;
			wrHit <= 1'b0;
			wrMem <= 1'b0;
			wrBheN <= 1'b1;
			memWrData <= 16'h0000;
			memWrLow <= 1'b0;
			memWrHigh <= 1'b0;
		end else begin
			addrLatch <= next_addrLatch;
			portADirection <= next_portADirection;
			portBDirection <= next_portBDirection;
			portAOutputData <= next_portAOutputData;
			portBOutputData <= next_portBOutputData;
			wrQ <= wrOn;
			if (wrOn) begin
				wrLo <= loLane;
				wrHi <= hiLane;
				wrOff <= regOff;
				wrHit <= bus.ioPortBaseSelect;
				wrMem <= bus.memSelect;
				wrBheN <= bus.highByteEnableN;
			end
			memWrData <= next_memWrData;
			memWrLow <= next_memWrLow;
			memWrHigh <= next_memWrHigh;
		end
	end

	// ==========================================================
	// Read path
	logic rdATgt;
	logic rdBTgt;
	logic [7:0] valA;
	logic [7:0] valB;
	logic loDrv;
	logic hiDrv;
	logic [7:0] loData;
	logic [7:0] hiData;

	// Base select wins over memory, memory over the track read, so a
	// decoder overlap never drives two sources onto one lane.
	always_comb begin
		rdATgt = ~regOff[0];
		rdBTgt = cfg.dataWide ? ~bus.highByteEnableN : regOff[0];
		unique case ({regOff[2:1], 1'b0})
			`CFGIO_OFF_PIN_A: begin
				valA = pinLevelA;
				valB = pinLevelB;
			end
			`CFGIO_OFF_DIR_A: begin
				valA = portADirection;
				valB = portBDirection;
			end
			`CFGIO_OFF_DAT_A: begin
				valA = portAOutputData;
				valB = portBOutputData;
			end
			default: begin
				valA = 8'h00;
				valB = 8'h00;
			end
		endcase
		loDrv = 1'b0;
		hiDrv = 1'b0;
		loData = 8'h00;
		hiData = 8'h00;
		if (rdOn & bus.ioPortBaseSelect) begin
			loDrv = rdATgt | (rdBTgt & ~cfg.dataWide);
			loData = rdATgt ? valA : valB;
			hiDrv = cfg.dataWide & rdBTgt;
			hiData = valB;
		end else if (rdOn & bus.memSelect) begin
			loDrv = 1'b1;
			loData = memRdData[7:0];
			hiDrv = cfg.dataWide & ~bus.highByteEnableN;
			hiData = memRdData[15:8];
		end else if (track & rdOn & bus.shareReadDecode) begin
			loDrv = 1'b1;
			loData = pinLevelA;
		end
	end

	// Multiplexed bus lanes are registered; non-multiplexed data goes via the ports.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lowBusOut <= 8'h00;
			lowBusOe <= 8'h00;
			highBusOut <= 8'h00;
			highBusOe <= 8'h00;
		end else begin
			lowBusOut <= loData;
			lowBusOe <= {8{loDrv & cfg.muxMode}};
			highBusOut <= hiData;
			highBusOe <= {8{hiDrv & cfg.muxMode}};
		end
	end

	// ==========================================================
	// Pin function selection
	logic [7:0] csN;
	logic [7:0] aAltOn;
	logic [7:0] aAltDrv;
	logic [7:0] aAltVal;
	logic [7:0] aOd;
	logic [7:0] bAltOn;
	logic [7:0] bAltDrv;
	logic [7:0] bAltVal;
	logic [7:0] bOd;

	// Drive select only shapes I/O, address and select outputs; bus modes are CMOS.
	always_comb begin
		if (nonMux) begin
			aAltOn = 8'hff;
			aAltDrv = {8{loDrv}};
			aAltVal = loData;
		end else if (track) begin
			aAltOn = 8'hff;
			// The write decode already carries the strobe qualifier.
			aAltDrv = {8{(bus.shareAddrOutDecode & aleOn) | bus.shareWriteDecode}};
			aAltVal = bus.lowAddrDataBus;
		end else begin
			aAltOn = cfg.addrOutSelect;
			aAltDrv = 8'hff;
			aAltVal = addrLatch;
		end
		aOd = cfg.portAOutputDriveSelect & {8{~(nonMux | track)}};
		if (wideNonMux) begin
			bAltOn = 8'hff;
			bAltDrv = {8{hiDrv}};
			bAltVal = hiData;
		end else begin
			bAltOn = ~cfg.portBIoSelect;
			bAltDrv = 8'hff;
			bAltVal = csN;
		end
		bOd = cfg.portBOutputDriveSelect & {8{~wideNonMux}};
	end

	assign chipSelectOutputs = csN;

	// ==========================================================
	// Pin cells and decoder terms
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : gPin
			cfgio_pin_cell uCellA (
				.clk(clk),
				.rst(rst),
				.pinIn(portAPinsIn[i]),
				.ioDrive(portADirection[i]),
				.ioVal(portAOutputData[i]),
				.altOn(aAltOn[i]),
				.altDrive(aAltDrv[i]),
				.altVal(aAltVal[i]),
				.openDrain(aOd[i]),
				.pinOut(portAPinsOut[i]),
				.pinOe(portAPinsOe[i]),
				.pinLevel(pinLevelA[i])
			);
			cfgio_pin_cell uCellB (
				.clk(clk),
				.rst(rst),
				.pinIn(portBPinsIn[i]),
				.ioDrive(portBDirection[i]),
				.ioVal(portBOutputData[i]),
				.altOn(bAltOn[i]),
				.altDrive(bAltDrv[i]),
				.altVal(bAltVal[i]),
				.openDrain(bOd[i]),
				.pinOut(portBPinsOut[i]),
				.pinOe(portBPinsOe[i]),
				.pinLevel(pinLevelB[i])
			);
			if (i < 4) begin : gWide
				cfgio_cs_term #(.TERMS(`CFGIO_PT_WIDE)) uCs (
					.terms(productTerms[`CFGIO_PT_WIDE*i +: `CFGIO_PT_WIDE]),
					.csN(csN[i])
				);
			end else begin : gNarrow
				cfgio_cs_term #(.TERMS(`CFGIO_PT_NARROW)) uCs (
					.terms(productTerms[4*`CFGIO_PT_WIDE + `CFGIO_PT_NARROW*(i-4) +: `CFGIO_PT_NARROW]),
					.csN(csN[i])
				);
			end
		end
	endgenerate

	// ==========================================================
	// Assertions
	// Port A bits left in plain I/O use, split by drive style, so any mix of styles is checked.
	logic [7:0] ioCmosA;
	logic [7:0] ioOdA;
	assign ioCmosA = ~cfg.addrOutSelect & ~cfg.portAOutputDriveSelect;
	assign ioOdA = ~cfg.addrOutSelect & cfg.portAOutputDriveSelect;
	AST_DIR_RESET: assert property (@(posedge clk) $fell(rst) |-> (portADirection == 8'h00 && portBDirection == 8'h00))
		else $error("Direction flops not cleared by reset.");
	AST_DIR_WRITE: assert property (@(posedge clk) disable iff (rst)
		(wrCommit && wrHit && wrATgt && wrBase == `CFGIO_OFF_DIR_A) |=> portADirection == $past(wrLo))
		else $error("Direction write not taken.");
	AST_PIN_RO: assert property (@(posedge clk) disable iff (rst)
		(wrCommit && wrBase == `CFGIO_OFF_PIN_A) |=> ($stable(portADirection) && $stable(portBOutputData)))
		else $error("Pin-level write changed port state.");
	AST_ADDR_LATCH: assert property (@(posedge clk) disable iff (rst)
		(cfg.muxMode && aleOn) ##1 !aleOn [*2] |-> addrLatch == $past(bus.lowAddrDataBus, 2))
		else $error("Address latch did not hold trailing-edge value.");
	AST_IO_OUT: assert property (@(posedge clk) disable iff (rst)
		(cfg.muxMode && !track)
		|=> ((portAPinsOe & ioCmosA) == ($past(portADirection) & ioCmosA)
		&& (portAPinsOut & ioCmosA) == ($past(portAOutputData) & ioCmosA)))
		else $error("I/O pin does not follow direction and data.");
	AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
		(cfg.muxMode && !track)
		|=> ((portAPinsOut & ioOdA) == 8'h00
		&& (portAPinsOe & ioOdA) == ($past(portADirection) & ~$past(portAOutputData) & ioOdA)))
		else $error("Open-drain pin drove high.");
	AST_TRACK_ADDR: assert property (@(posedge clk) disable iff (rst)
		(track && bus.shareAddrOutDecode && aleOn)
		|=> (portAPinsOe == 8'hff && portAPinsOut == $past(bus.lowAddrDataBus)))
		else $error("Track address not passed out.");
	AST_TRACK_IDLE: assert property (@(posedge clk) disable iff (rst)
		(track && !(bus.shareAddrOutDecode && aleOn) && !bus.shareWriteDecode) |=> portAPinsOe == 8'h00)
		else $error("Track port driven while idle.");
	AST_TRACK_READ: assert property (@(posedge clk) disable iff (rst)
		(track && rdOn && bus.shareReadDecode && !bus.ioPortBaseSelect && !bus.memSelect)
		|=> (lowBusOe == 8'hff && lowBusOut == $past(pinLevelA)))
		else $error("Track read did not drive the low bus.");
	AST_CHIP_SELECT: assert property (@(posedge clk) disable iff (rst)
		(!rst && !wideNonMux && cfg.portBIoSelect == 8'h00 && cfg.portBOutputDriveSelect == 8'h00)
		|=> (portBPinsOe == 8'hff && portBPinsOut == $past(csN)))
		else $error("Port B does not carry chip-selects.");
endmodule

// [verification/cfgio_host_model.sv]
`timescale 1ns/100ps
// ====
// Host controller model: drives the latch strobe, the read and write strobes and the bus lanes.
module cfgio_host_model import cfgio_pkg::*; (
	input wire logic clk,
	input wire logic style,
	input wire logic [15:0] rdBus,
	output cfgio_bus_type bus
);
	// Start with both strobes inactive for the separate-strobe style.
	initial begin
		bus = '0;
		bus.rdE = 1'b1;
		bus.wrRw = 1'b1;
	end

	// Released lanes show the inverse of their last value, so stale data never passes for an answer.
	function automatic cfgio_bus_type idle();
		cfgio_bus_type v;
		v = '0;
		v.rdE = ~style;
		v.wrRw = 1'b1;
		v.lowAddrDataBus = ~bus.lowAddrDataBus;
		v.highAddrDataBus = ~bus.highAddrDataBus;
		return v;
	endfunction

	// Apply one bus state just after an edge and keep it for n edges.
	task automatic hold(input cfgio_bus_type v, input int n);
		bus <= v;
		repeat (n) @(posedge clk);
	endtask

	// One complete access; the strobe length varies so slow hosts are covered too.
	task automatic access(input logic isWr, input logic [7:0] adr, input logic [7:0] wd, input logic sel,
		input logic high_byte_enable, output logic [15:0] rd);
		cfgio_bus_type v;
		v = idle();
		v.ale = 1'b1;
		v.lowAddrDataBus = adr;
		v.addr = adr[2:0];
		v.highByteEnableN = high_byte_enable;
		hold(v, 3);
		v.ale = 1'b0;
		hold(v, 3);
		v.lowAddrDataBus = isWr ? wd : ~adr;
		v.ioPortBaseSelect = ~sel;
		v.memSelect = sel;
		if (style) begin
			v.rdE = 1'b1;
			v.wrRw = ~isWr;
		end else if (isWr) begin
			v.wrRw = 1'b0;
		end else begin
			v.rdE = 1'b0;
		end
		hold(v, 5 + int'($urandom_range(3)));
		rd = rdBus;
		v.rdE = ~style;
		v.wrRw = 1'b1;
		hold(v, 4);
		hold(idle(), 3);
	endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
// ====
// Self-checking bench for the two configurable ports.
module tb_top import cfgio_pkg::*;;
	logic clk;
	logic rst;
	cfgio_cfg_type cfg;
	cfgio_bus_type busIn;
	logic [23:0] productTerms;
	logic [15:0] memRdData, rdBus, memWrData, capW, rd, w16;
	logic [7:0] extA, extB, extAOe, extBOe, lastAdr, w, io, dirM[2], datM[2];
	logic [7:0] aOut, aOe, bOut, bOe, lowBusOut, lowBusOe, highBusOut, highBusOe, chipSelectOutputs;
	logic memWrLow, memWrHigh;
	wire [7:0] portAPinsIn, portBPinsIn;
	int err_count, checks_done, wrCnt, n;

	// Every pin has a board pull-up; the far device drives only where the port does not.
	assign portAPinsIn = (aOe & aOut) | (~aOe & ((extAOe & extA) | ~extAOe));
	assign portBPinsIn = (bOe & bOut) | (~bOe & ((extBOe & extB) | ~extBOe));
	assign rdBus = cfg.muxMode ? {highBusOut, lowBusOut} : {bOut, aOut};

	// 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	cfgio_ports i_dut (.clk(clk), .rst(rst), .cfg(cfg), .busIn(busIn), .productTerms(productTerms),
		.memRdData(memRdData), .portAPinsIn(portAPinsIn), .portAPinsOut(aOut), .portAPinsOe(aOe),
		.portBPinsIn(portBPinsIn), .portBPinsOut(bOut), .portBPinsOe(bOe), .lowBusOut(lowBusOut),
		.lowBusOe(lowBusOe), .highBusOut(highBusOut), .highBusOe(highBusOe),
		.chipSelectOutputs(chipSelectOutputs), .memWrData(memWrData), .memWrLow(memWrLow), .memWrHigh(memWrHigh));

	cfgio_host_model i_host (.clk(clk), .style(cfg.strobeStyleSelect), .rdBus(rdBus), .bus(busIn));

	// Count memory write pulses away from the edge that launches them.
	always @(negedge clk) begin
		if (memWrLow) begin
			wrCnt++;
			capW[7:0] = memWrData[7:0];
		end
		if (memWrHigh) begin
			wrCnt++;
			capW[15:8] = memWrData[15:8];
		end
	end

	// Reference chip-selects: selects 0-3 take four terms, 4-7 take two.
	function automatic logic [7:0] csM(input logic [23:0] t);
		for (int i = 0; i < 8; i++)
			csM[i] = (i < 4) ? ~|t[4*i +: 4] : ~|t[16 + 2*(i-4) +: 2];
	endfunction

	// An open-drain pin only drives while its data is low.
	function automatic logic [7:0] drvM(input int p);
		return dirM[p] & ~((p ? cfg.portBOutputDriveSelect : cfg.portAOutputDriveSelect) & datM[p]);
	endfunction

	function automatic logic [7:0] lvlM(input int p);
		logic [7:0] d, e, eo;
		d = drvM(p);
		e = p ? extB : extA;
		eo = p ? extBOe : extAOe;
		return (d & datM[p]) | (~d & (~eo | e));
	endfunction

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic acc(input logic isWr, input logic sel, input logic high_byte_enable, input logic [2:0] off,
		input logic [7:0] wd, output logic [15:0] r);
		lastAdr = {5'($urandom), off};
		i_host.access(isWr, lastAdr, wd, sel, high_byte_enable, r);
	endtask

	// Configuration only changes under reset; the model forgets its flops there too.
	task automatic restart(input cfgio_cfg_type c);
		rst <= 1'b1;
		cfg <= c;
		extAOe <= 8'h00;
		extBOe <= 8'h00;
		dirM = '{8'h00, 8'h00};
		datM = '{8'h00, 8'h00};
		@(posedge clk);
		i_host.hold(i_host.idle(), 9);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end

	// Blank part, registers and pins, track mode, then the 16-bit data bus.
	initial begin
		cfgio_cfg_type c;
		cfgio_bus_type v;
		void'($urandom(9690));
		{rst, cfg, productTerms, memRdData, extA, extB, extAOe, extBOe, wrCnt} = '0;
		restart('0);
		productTerms <= 24'($urandom);
		repeat (4) @(posedge clk);
		chk("aOeBlank", 8'h00, aOe);
		chk("bOeBlank", 8'hff, bOe);
		chk("bOutBlank", csM(productTerms), bOut);
		c = '0;
		c.muxMode = 1'b1;
		c.addrOutSelect = 8'h81;
		c.portAOutputDriveSelect = (8'($urandom) & 8'h3c) | 8'h02; // Bit 1 always open drain, bit 6 always push-pull.
		c.portBIoSelect = 8'h5a;
		c.portBOutputDriveSelect = 8'($urandom);
		io = c.portBIoSelect;
		restart(c);
		for (int i = 0; i < 28; i++) begin
			productTerms <= (i < 24) ? 24'h1 << i : 24'($urandom);
			repeat (4) @(posedge clk);
			chk("chipSelect", csM(productTerms), chipSelectOutputs);
			chk("csPins", csM(productTerms) & ~io, portBPinsIn & ~io);
		end
		for (int k = 0; k < 6; k++) begin
			for (int p = 0; p < 4; p++) begin
				w = 8'($urandom);
				acc(1'b1, 1'b0, 1'b1, 3'(4 + p), w, rd);
				if (p < 2)
					dirM[p] = w;
				else
					datM[p - 2] = w;
			end
			acc(1'b1, 1'b0, 1'b1, 3'h2, 8'($urandom), rd);
			acc(1'b1, 1'b0, 1'b1, 3'h3, 8'($urandom), rd);
			extA <= 8'($urandom);
			extB <= 8'($urandom);
			extAOe <= 8'($urandom) & ~dirM[0] & 8'h7e;
			extBOe <= 8'($urandom) & ~dirM[1] & io;
			for (int p = 0; p < 4; p++) begin
				acc(1'b0, 1'b0, 1'b1, 3'(4 + p), 8'h00, rd);
				chk("regRead", (p < 2) ? dirM[p] : datM[p - 2], rd[7:0]);
			end
			acc(1'b0, 1'b0, 1'b1, 3'h2, 8'h00, rd);
			chk("pinA", (lastAdr & 8'h81) | (lvlM(0) & 8'h7e), rd[7:0]);
			acc(1'b0, 1'b0, 1'b1, 3'h3, 8'h00, rd);
			chk("pinB", (lvlM(1) & io) | (csM(productTerms) & ~io), rd[7:0]);
			chk("aOe", (drvM(0) & 8'h7e) | 8'h81, aOe);
			chk("aOut", (datM[0] & drvM(0) & 8'h7e) | (lastAdr & 8'h81), aOut & aOe);
			chk("bOe", drvM(1) & io, bOe & io);
			chk("bOut", datM[1] & drvM(1) & io, bOut & bOe & io);
		end
		c = '0;
		c.muxMode = 1'b1;
		c.portATrackSelect = 1'b1;
		restart(c);
		for (int k = 0; k < 4; k++) begin
			v = i_host.idle();
			w = 8'($urandom);
			v.ale = 1'b1;
			v.shareAddrOutDecode = 1'b1;
			v.lowAddrDataBus = w;
			i_host.hold(v, 5);
			chk("trackAddrOe", 8'hff, aOe);
			chk("trackAddr", w, aOut);
			v.ale = 1'b0;
			v.lowAddrDataBus = ~w;
			i_host.hold(v, 5);
			chk("trackGapOe", 8'h00, aOe);
			w = 8'($urandom);
			v.shareAddrOutDecode = 1'b0;
			v.wrRw = 1'b0;
			v.shareWriteDecode = 1'b1;
			v.lowAddrDataBus = w;
			i_host.hold(v, 5);
			chk("trackWrOe", 8'hff, aOe);
			chk("trackWr", w, aOut);
			v.wrRw = 1'b1;
			v.shareWriteDecode = 1'b0;
			v.lowAddrDataBus = ~w;
			i_host.hold(v, 3);
			extA <= 8'($urandom);
			extAOe <= 8'hff;
			v.shareReadDecode = 1'b1;
			v.rdE = 1'b0;
			i_host.hold(v, 5);
			chk("trackRdOe", 8'hff, lowBusOe);
			chk("trackRd", extA, lowBusOut);
			chk("trackRdPinOe", 8'h00, aOe);
			extAOe <= 8'h00;
			i_host.hold(i_host.idle(), 5);
			chk("trackIdleOe", 8'h00, aOe | lowBusOe);
		end
		c = '0;
		c.dataWide = 1'b1;
		c.strobeStyleSelect = 1'b1;
		c.portBIoSelect = 8'hff;
		restart(c);
		for (int k = 0; k < 3; k++) begin
			w16 = 16'($urandom);
			{extB, extA, extBOe, extAOe} <= {w16, 16'hffff};
			n = wrCnt;
			acc(1'b1, 1'b1, 1'b0, 3'(2 * k), 8'h00, rd);
			chk("memWrCount", 8'd2, 8'(wrCnt - n));
			chk("memWrLo", w16[7:0], capW[7:0]);
			chk("memWrHi", w16[15:8], capW[15:8]);
			{extBOe, extAOe} <= 16'h0000;
			memRdData <= 16'($urandom);
			acc(1'b0, 1'b1, 1'b0, 3'(2 * k), 8'h00, rd);
			chk("memRdLo", memRdData[7:0], rd[7:0]);
			chk("memRdHi", memRdData[15:8], rd[15:8]);
		end
		w16 = 16'($urandom);
		{extB, extA, extBOe, extAOe} <= {w16, 16'hffff};
		acc(1'b1, 1'b0, 1'b0, 3'h4, 8'h00, rd);
		{extB, extA} <= 16'($urandom);
		acc(1'b1, 1'b0, 1'b1, 3'h4, 8'h00, rd);
		w = extA;
		{extBOe, extAOe} <= 16'h0000;
		acc(1'b0, 1'b0, 1'b0, 3'h4, 8'h00, rd);
		chk("wordDirLo", w, rd[7:0]);
		chk("wordDirHi", w16[15:8], rd[15:8]);
		conclude();
	end
endmodule
